// ==== rtl/irq_lost_rom_params.svh ====
`ifndef IRQ_LOST_ROM_PARAMS_SVH
`define IRQ_LOST_ROM_PARAMS_SVH

// Register byte offsets
`define OFS_IRQ_ENABLE        8'h38
`define OFS_LOST_PACKET_COUNT 8'h40
`define OFS_SERIAL_ROM_PORT   8'h48

// Interrupt enable register fields
`define BIT_NORMAL_CLASS_EN   16
`define BIT_ABNORMAL_CLASS_EN 15
`define BIT_FATAL_BUS_ERR_EN  13
`define BIT_TIMER_EXPIRY_EN   11
`define BIT_RX_WATCHDOG_EN    9
`define BIT_RX_STOPPED_EN     8
`define BIT_RX_DESC_UNAVAIL_EN 7
`define BIT_RX_DONE_EN        6
`define BIT_TX_UNDERFLOW_EN   5
`define BIT_TX_JABBER_EN      3
`define BIT_TX_DESC_UNAVAIL_EN 2
`define BIT_TX_STOPPED_EN     1
`define BIT_TX_DONE_EN        0
`define IRQ_ENABLE_WMASK      17'h1ABEF
`define IRQ_ENABLE_RESET      17'h00000
`define IRQ_SRC_WIDTH         17

// Lost packet counter fields
`define LOST_COUNT_WIDTH      16
`define BIT_LOST_OVERFLOW     16
`define LOST_COUNT_RESET      16'h0000

// Serial rom port fields
`define BIT_ROM_READ_CTRL     14
`define BIT_ROM_WRITE_CTRL    13
`define BIT_ROM_PATH_SELECT   11
`define BIT_ROM_FROM_CHIP     3
`define BIT_ROM_TO_CHIP       2
`define BIT_ROM_CLK           1
`define BIT_ROM_CS            0
`define ROM_PIN_RESET         1'b1
`define ROM_CTRL_RESET        1'b0

`endif

// ==== rtl/irq_lost_rom_pkg.sv ====
package irq_lost_rom_pkg;

  typedef enum logic [1:0] {
    SEL_NONE = 2'b00,
    SEL_IRQ  = 2'b01,
    SEL_LOST = 2'b10,
    SEL_ROM  = 2'b11
  } reg_sel_e;

  typedef enum logic {
    PH_IDLE   = 1'b0,
    PH_ANSWER = 1'b1
  } apb_phase_e;

  typedef struct packed {
    logic rd;
    logic wr;
    logic sel;
    logic di;
    logic clk;
    logic cs;
  } rom_port_s;

endpackage : irq_lost_rom_pkg

// ==== rtl/rom_sync_if.sv ====
`timescale 1ns/1ps
`default_nettype none

interface rom_sync_if;
  logic raw;
  logic synced;

  modport sync_side (input raw, output synced);
  modport user_side (output raw, input synced);
endinterface : rom_sync_if

`default_nettype wire

// ==== rtl/rom_pin_sync.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "irq_lost_rom_params.svh"

module rom_pin_sync
(
  // Clock and reset
  input  wire logic          clk,
  input  wire logic          srst,
  // Pin path
  rom_sync_if.sync_side      port
);

  logic stage1;
  logic stage2;

  // Two flops, first one read only by the second
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      stage1 <= `ROM_PIN_RESET;
      stage2 <= `ROM_PIN_RESET;
    end
    else
    begin
      stage1 <= port.raw;
      stage2 <= stage1;
    end
  end

  assign port.synced = stage2;

endmodule : rom_pin_sync

`default_nettype wire

// ==== rtl/irq_enable_lost_count_rom_port.sv ====
// Functional notes
// R1 - Normal enable gates all normal sources
// R2 - Abnormal enable gates all abnormal sources
// R3 - Fatal bus error needs bit13 and abnormal
// R4 - Timer expiry needs bit11 and abnormal
// R5 - Rx watchdog needs bit9 and abnormal
// R6 - Rx stopped needs bit8 and abnormal
// R7 - Rx descriptor unavailable needs bit7, abnormal
// R8 - Rx done needs bit6 and normal
// R9 - Tx underflow needs bit5 and abnormal
// R10 - Tx jabber needs bit3 and abnormal
// R11 - Tx descriptor unavailable needs bit2, normal
// R12 - Tx stopped needs bit1 and abnormal
// R13 - Tx done needs bit0 and normal
// R14 - Count packets lost for lack of descriptors
// R15 - Reading lost count returns then clears it
// R16 - Overflow flag sticky until read
// R17 - Rom read enabled with read bit and select
// R18 - Rom write enabled with write bit and select
// R19 - Select clear disables rom access
// R20 - Bit3 reads rom data, resets to one
// R21 - Bit2 drives rom data line, resets one
// R22 - Bit1 drives rom clock, resets one
// R23 - Bit0 drives rom chip select, resets one
// R24 - Interrupt when enabled flag in enabled class
//
// The APB register port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
`include "irq_lost_rom_params.svh"

module irq_enable_lost_count_rom_port
  import irq_lost_rom_pkg::*;
(
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        srst,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output var  logic        pready,
  output var  logic [31:0] prdata,
  output var  logic        pslverr,
  // Interrupt sources and output
  input  wire logic [16:0] irq_status_flags,
  output var  logic        irq,
  // Lost packet event
  input  wire logic        rx_lost_pkt,
  // Serial rom pins
  input  wire logic        rom_serial_from_chip,
  output var  logic        rom_serial_to_chip,
  output var  logic        rom_clk,
  output var  logic        rom_cs,
  output var  logic        rom_read_en,
  output var  logic        rom_write_en
);

  // Address decode shared by read and write paths
  function automatic reg_sel_e decode(input logic [7:0] addr);
    reg_sel_e sel;
    case (addr)
      `OFS_IRQ_ENABLE:        sel = SEL_IRQ;
      `OFS_LOST_PACKET_COUNT: sel = SEL_LOST;
      `OFS_SERIAL_ROM_PORT:   sel = SEL_ROM;
      default:                sel = SEL_NONE;
    endcase
    return sel;
  endfunction : decode

  // Which summary enable governs each source bit
  function automatic logic is_normal(input int idx);
    logic n;
    case (idx)
      `BIT_RX_DONE_EN:         n = 1'b1; // R8
      `BIT_TX_DESC_UNAVAIL_EN: n = 1'b1; // R11
      `BIT_TX_DONE_EN:         n = 1'b1; // R13
      default:                 n = 1'b0;
    endcase
    return n;
  endfunction : is_normal

  function automatic logic is_abnormal(input int idx);
    logic a;
    case (idx)
      `BIT_FATAL_BUS_ERR_EN:   a = 1'b1; // R3
      `BIT_TIMER_EXPIRY_EN:    a = 1'b1; // R4
      `BIT_RX_WATCHDOG_EN:     a = 1'b1; // R5
      `BIT_RX_STOPPED_EN:      a = 1'b1; // R6
      `BIT_RX_DESC_UNAVAIL_EN: a = 1'b1; // R7
      `BIT_TX_UNDERFLOW_EN:    a = 1'b1; // R9
      `BIT_TX_JABBER_EN:       a = 1'b1; // R10
      `BIT_TX_STOPPED_EN:      a = 1'b1; // R12
      default:                 a = 1'b0;
    endcase
    return a;
  endfunction : is_abnormal

  // State
  apb_phase_e                      phase;
  logic [`IRQ_SRC_WIDTH-1:0]       irq_enable_reg;
  logic [`LOST_COUNT_WIDTH-1:0]    lost_packet_count;
  logic                            lost_count_overflow;
  rom_port_s                       serial_rom_port_reg;
  logic [`IRQ_SRC_WIDTH-1:0]       gated_src;
  logic                            next_irq;
  logic [31:0]                     next_prdata;
  logic                            rom_from_chip_sync;

  // Bus handshake, decode, class enable and counter-full terms
  logic                            take;
  logic                            commit;
  reg_sel_e                        sel;
  logic                            normal_class_enable;
  logic                            abnormal_class_enable;
  logic                            count_full;

  assign sel                   = decode(paddr);
  assign take                  = psel && penable && (phase == PH_IDLE);
  assign commit                = psel && penable && pready;
  assign normal_class_enable   = irq_enable_reg[`BIT_NORMAL_CLASS_EN];
  assign abnormal_class_enable = irq_enable_reg[`BIT_ABNORMAL_CLASS_EN];
  assign count_full            = &lost_packet_count;

  // Rom data pin synchroniser
  rom_sync_if u_rom_if ();

  assign u_rom_if.raw       = rom_serial_from_chip;
  assign rom_from_chip_sync = u_rom_if.synced;

  rom_pin_sync u_rom_pin_sync
  (
    .clk  (ref_clk),
    .srst (srst),
    .port (u_rom_if.sync_side)
  );

  // APB phase tracking
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      phase <= PH_IDLE;
    end
    else
    begin
      case (phase)
        PH_IDLE:
        begin
          if (take)
          begin
            phase <= PH_ANSWER;
          end
        end
        PH_ANSWER:
        begin
          phase <= PH_IDLE;
        end
        default:
        begin
          phase <= PH_IDLE;
        end
      endcase
    end
  end

  // APB answer
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end
    else
    begin
      pready  <= take;
      pslverr <= take && (sel == SEL_NONE);
      if (take)
      begin
        prdata <= next_prdata;
      end
    end
  end

  // Read data mux
  always_comb
  begin
    next_prdata = 32'h00000000;
    if (!pwrite)
    begin
      case (sel)
        SEL_IRQ:
        begin
          next_prdata[`IRQ_SRC_WIDTH-1:0] = irq_enable_reg;
        end
        SEL_LOST:
        begin
          next_prdata[`LOST_COUNT_WIDTH-1:0] = lost_packet_count; // R15
          next_prdata[`BIT_LOST_OVERFLOW]    = lost_count_overflow; // R16
        end
        SEL_ROM:
        begin
          next_prdata[`BIT_ROM_READ_CTRL]   = serial_rom_port_reg.rd;
          next_prdata[`BIT_ROM_WRITE_CTRL]  = serial_rom_port_reg.wr;
          next_prdata[`BIT_ROM_PATH_SELECT] = serial_rom_port_reg.sel;
          next_prdata[`BIT_ROM_FROM_CHIP]   = rom_from_chip_sync; // R20
          next_prdata[`BIT_ROM_TO_CHIP]     = serial_rom_port_reg.di;
          next_prdata[`BIT_ROM_CLK]         = serial_rom_port_reg.clk;
          next_prdata[`BIT_ROM_CS]          = serial_rom_port_reg.cs;
        end
        default:
        begin
          next_prdata = 32'h00000000;
        end
      endcase
    end
  end

  // Interrupt enable register
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      irq_enable_reg <= `IRQ_ENABLE_RESET;
    end
    else if (commit && pwrite && (sel == SEL_IRQ))
    begin
      irq_enable_reg <= pwdata[`IRQ_SRC_WIDTH-1:0] & `IRQ_ENABLE_WMASK;
    end
  end

  // Per-source gating by own enable and class summary
  generate
    for (genvar i = 0; i < `IRQ_SRC_WIDTH; i++)
    begin : g_src
      if (is_normal(i))
      begin : g_norm
        assign gated_src[i] = irq_status_flags[i] & irq_enable_reg[i] & normal_class_enable; // R1
      end
      else if (is_abnormal(i))
      begin : g_abn
        assign gated_src[i] = irq_status_flags[i] & irq_enable_reg[i] & abnormal_class_enable; // R2
      end
      else
      begin : g_none
        assign gated_src[i] = 1'b0;
      end
    end
  endgenerate

  assign next_irq = |gated_src;

  // Interrupt output
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      irq <= 1'b0;
    end
    else
    begin
      irq <= next_irq; // R24
    end
  end

  // Lost packet counter, clear-on-read wins, a same-cycle event restarts it at one
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      lost_packet_count <= `LOST_COUNT_RESET;
    end
    else if (take && !pwrite && (sel == SEL_LOST))
    begin
      lost_packet_count <= rx_lost_pkt ? 16'h0001 : `LOST_COUNT_RESET; // R15
    end
    else if (rx_lost_pkt)
    begin
      lost_packet_count <= lost_packet_count + 16'h0001; // R14
    end
  end

  // Overflow flag, set beats clear-on-read
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      lost_count_overflow <= 1'b0;
    end
    else if (rx_lost_pkt && count_full)
    begin
      lost_count_overflow <= 1'b1; // R16
    end
    else if (take && !pwrite && (sel == SEL_LOST))
    begin
      lost_count_overflow <= 1'b0; // R16
    end
  end

  // Serial rom port register
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      serial_rom_port_reg.rd  <= `ROM_CTRL_RESET;
      serial_rom_port_reg.wr  <= `ROM_CTRL_RESET;
      serial_rom_port_reg.sel <= `ROM_CTRL_RESET;
      serial_rom_port_reg.di  <= `ROM_PIN_RESET;
      serial_rom_port_reg.clk <= `ROM_PIN_RESET;
      serial_rom_port_reg.cs  <= `ROM_PIN_RESET;
    end
    else if (commit && pwrite && (sel == SEL_ROM))
    begin
      serial_rom_port_reg.rd  <= pwdata[`BIT_ROM_READ_CTRL];
      serial_rom_port_reg.wr  <= pwdata[`BIT_ROM_WRITE_CTRL];
      serial_rom_port_reg.sel <= pwdata[`BIT_ROM_PATH_SELECT];
      serial_rom_port_reg.di  <= pwdata[`BIT_ROM_TO_CHIP];
      serial_rom_port_reg.clk <= pwdata[`BIT_ROM_CLK];
      serial_rom_port_reg.cs  <= pwdata[`BIT_ROM_CS];
    end
  end

  // Serial rom pins and access enables
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      rom_serial_to_chip <= `ROM_PIN_RESET;
      rom_clk            <= `ROM_PIN_RESET;
      rom_cs             <= `ROM_PIN_RESET;
      rom_read_en        <= 1'b0;
      rom_write_en       <= 1'b0;
    end
    else
    begin
      rom_serial_to_chip <= serial_rom_port_reg.di; // R21
      rom_clk            <= serial_rom_port_reg.clk; // R22
      rom_cs             <= serial_rom_port_reg.cs; // R23
      rom_read_en        <= serial_rom_port_reg.rd & serial_rom_port_reg.sel; // R17 R19
      rom_write_en       <= serial_rom_port_reg.wr & serial_rom_port_reg.sel; // R18 R19
    end
  end

endmodule : irq_enable_lost_count_rom_port

`default_nettype wire

// ==== verification/irq_lost_rom_properties.sv ====
`timescale 1ns/1ps
`default_nettype none

module irq_lost_rom_properties
(
  // Clock and reset
  input wire logic        ref_clk,
  input wire logic        srst,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  // Interrupt and rom pins
  input wire logic [16:0] irq_status_flags,
  input wire logic        irq,
  input wire logic        rom_serial_to_chip,
  input wire logic        rom_clk,
  input wire logic        rom_cs,
  input wire logic        rom_read_en,
  input wire logic        rom_write_en
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);

  logic wr_rom;
  assign wr_rom = psel && penable && pready && pwrite && paddr == 8'h48;

  a_pready_one_wait: assert property (psel && penable && !pready |=> pready)
    else $error("pready late");
  a_pready_pulse: assert property (pready |=> !pready)
    else $error("pready held");
  a_slverr_decode: assert property (pready |-> pslverr == !(paddr inside {8'h38, 8'h40, 8'h48}))
    else $error("bad pslverr");
  a_irq_quiet: assert property ((irq_status_flags & 17'h02BEF) == 17'h0 |=> !irq)
    else $error("irq without source");
  a_rom_pins: assert property (wr_rom |-> ##2 {rom_serial_to_chip, rom_clk, rom_cs} == $past(pwdata[2:0], 2))
    else $error("rom pins wrong");
  a_rom_read_gate: assert property (wr_rom |->
    ##2 rom_read_en == ($past(pwdata[14], 2) && $past(pwdata[11], 2)))
    else $error("read enable wrong");
  a_rom_write_gate: assert property (wr_rom |->
    ##2 rom_write_en == ($past(pwdata[13], 2) && $past(pwdata[11], 2)))
    else $error("write enable wrong");
  a_rom_hold: assert property (!wr_rom && !$past(wr_rom) |=>
    $stable({rom_serial_to_chip, rom_clk, rom_cs, rom_read_en, rom_write_en}))
    else $error("rom pins moved");
  a_rsvd_zero: assert property (pready && !pwrite |->
    (prdata & ~(paddr == 8'h38 ? 32'h1ABEF : paddr == 8'h40 ? 32'h1FFFF : 32'h680F)) == 32'h0)
    else $error("reserved bits set");

  c_overflow: cover property (pready && paddr == 8'h40 && prdata[16]);
  c_irq: cover property ($rose(irq));
  c_slverr: cover property (pslverr);
endmodule : irq_lost_rom_properties

`default_nettype wire

// ==== verification/serial_rom_model.sv ====
`timescale 1ns/1ps
`default_nettype none

module serial_rom_model
#(
  parameter logic [15:0] PATTERN = 16'hA5C3
)
(
  // Pins from the block
  input  wire logic rom_cs,
  input  wire logic rom_clk,
  input  wire logic rom_serial_to_chip,
  // Data back, pulled up when idle
  output wire logic rom_serial_from_chip
);
  logic [15:0] sr = PATTERN;
  logic        cs_d = 1'b1;
  logic        clk_d = 1'b1;

  // Reload on select, shift on rising clock
  always @(rom_cs or rom_clk)
  begin
    if (rom_cs === 1'b1 && cs_d === 1'b0)
      sr = PATTERN;
    else if (rom_cs === 1'b1 && rom_clk === 1'b1 && clk_d === 1'b0)
      sr = {sr[14:0], rom_serial_to_chip};
    cs_d = rom_cs;
    clk_d = rom_clk;
  end

  assign rom_serial_from_chip = (rom_cs === 1'b1) ? sr[15] : 1'b1;
endmodule : serial_rom_model

`default_nettype wire

// ==== verification/irq_enable_lost_count_rom_port_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none

`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin errors++; $display("ERROR %0t got %h exp %h", $time, g, e); end end

module irq_enable_lost_count_rom_port_tb_top;
  localparam logic [15:0] PAT = 16'hA5C3;
  logic        ref_clk = 1'b0;
  logic        srst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [16:0] irq_status_flags = 17'h0;
  logic        rx_lost_pkt = 1'b0;
  logic [31:0] prdata, rd;
  logic        pready, pslverr, irq, er, rom_serial_from_chip, rom_serial_to_chip, rom_clk, rom_cs;
  logic        rom_read_en, rom_write_en;
  int          errors = 0;
  int          n_checks = 0;

  always #25 ref_clk = ~ref_clk;

  irq_enable_lost_count_rom_port i_irq_enable_lost_count_rom_port (.ref_clk, .srst, .psel, .penable, .pwrite,
    .paddr, .pwdata, .pready, .prdata, .pslverr, .irq_status_flags, .irq, .rx_lost_pkt, .rom_serial_from_chip,
    .rom_serial_to_chip, .rom_clk, .rom_cs, .rom_read_en, .rom_write_en);

  serial_rom_model #(.PATTERN(PAT)) i_serial_rom_model (.rom_cs, .rom_clk, .rom_serial_to_chip,
    .rom_serial_from_chip);

  task test_done;
    if (errors == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : test_done

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge ref_clk);
      k++;
    end
    while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1)
    begin
      errors++;
      $display("ERROR %0t no pready", $time);
      test_done();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task t_reset;
    apb(1'b0, 8'h38, 32'h0);
    `CHK(rd, 32'h0)
    apb(1'b0, 8'h48, 32'h0);
    `CHK(rd, 32'hF)
    apb(1'b1, 8'h3C, 32'hFFFFFFFF);
    `CHK(er, 1'b1)
  endtask : t_reset

  task t_irq;
    logic [16:0] cfg [4] = '{17'h1ABEF, 17'h0ABEF, 17'h12BEF, 17'h18000};
    logic [16:0] en;
    apb(1'b1, 8'h38, 32'hFFFFFFFF);
    apb(1'b0, 8'h38, 32'h0);
    `CHK(rd, 32'h1ABEF)
    foreach (cfg[c])
    begin
      apb(1'b1, 8'h38, {15'h0, cfg[c]});
      en = cfg[c] & ((cfg[c][16] ? 17'h00045 : 17'h0) | (cfg[c][15] ? 17'h02BAA : 17'h0));
      for (int i = 0; i < 17; i++)
      begin
        irq_status_flags <= 17'h1 << i;
        repeat (3) @(posedge ref_clk);
        `CHK(irq, en[i])
      end
    end
    irq_status_flags <= 17'h0;
  endtask : t_irq

  task t_lost;
    rx_lost_pkt <= 1'b1;
    repeat (5) @(posedge ref_clk);
    rx_lost_pkt <= 1'b0;
    apb(1'b0, 8'h40, 32'h0);
    `CHK(rd, 32'h5)
    apb(1'b0, 8'h40, 32'h0);
    `CHK(rd, 32'h0)
    rx_lost_pkt <= 1'b1;
    repeat (65537) @(posedge ref_clk);
    rx_lost_pkt <= 1'b0;
    apb(1'b0, 8'h40, 32'h0);
    `CHK(rd, 32'h10001)
    apb(1'b0, 8'h40, 32'h0);
    `CHK(rd, 32'h0)
  endtask : t_lost

  task t_rom;
    logic [31:0] w [4] = '{32'h4800, 32'h2800, 32'h6000, 32'h6805};
    foreach (w[c])
    begin
      apb(1'b1, 8'h48, w[c] | 32'hFFFF97F8);
      repeat (2) @(posedge ref_clk);
      `CHK({rom_read_en, rom_write_en}, {w[c][14] & w[c][11], w[c][13] & w[c][11]})
      `CHK({rom_serial_to_chip, rom_clk, rom_cs}, w[c][2:0])
    end
    for (int b = 15; b > 7; b--)
    begin
      apb(1'b0, 8'h48, 32'h0);
      `CHK(rd, 32'h6805 | {28'h0, PAT[b], 3'h0})
      apb(1'b1, 8'h48, 32'h6807);
      apb(1'b1, 8'h48, 32'h6805);
    end
    apb(1'b1, 8'h48, 32'h6800);
    apb(1'b0, 8'h48, 32'h0);
    `CHK(rd, 32'h6808)
  endtask : t_rom

  initial
  begin
    repeat (5) @(posedge ref_clk);
    srst <= 1'b0;
    t_reset();
    t_irq();
    t_lost();
    t_rom();
    test_done();
  end
endmodule : irq_enable_lost_count_rom_port_tb_top

bind irq_enable_lost_count_rom_port irq_lost_rom_properties i_irq_lost_rom_properties (.ref_clk, .srst, .psel,
  .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr, .irq_status_flags, .irq, .rom_serial_to_chip,
  .rom_clk, .rom_cs, .rom_read_en, .rom_write_en);

`default_nettype wire
